// [shared/bcc_map.vh]
/*
  Register offsets, field positions, mode codes, reset values and timing
  constants for the cell balance controller.
  Assumes a 10 MHz reference clock and inclusion by bare name.
*/
`ifndef BCC_MAP_VH
`define BCC_MAP_VH

// Register offsets
`define BCC_ADDR_SETUP 6'h13
`define BCC_ADDR_STATUS 6'h14

// Setup register fields
`define BCC_MODE_LSB 0
`define BCC_MODE_MSB 1
`define BCC_WAIT_LSB 2
`define BCC_WAIT_MSB 4
`define BCC_PTR_LO_LSB 5
`define BCC_PTR_LO_MSB 7
`define BCC_PTR_HI_BIT 8
`define BCC_GO_BIT 9

// Mode codes
`define BCC_MODE_OFF 2'h0
`define BCC_MODE_MANUAL 2'h1
`define BCC_MODE_TIMED 2'h2
`define BCC_MODE_AUTO 2'h3

// Reset values
`define BCC_SETUP_RST 10'h000
`define BCC_STATUS_RST 12'h000

// Status pointer value of the manual and timed copy
`define BCC_PTR_MAIN 4'h0

// Timing: one second, clock period, and cycles per second
`define BCC_SEC_NS 1000000000
`define BCC_CLK_NS 100
`define BCC_CYC_PER_SEC (`BCC_SEC_NS / `BCC_CLK_NS)

`endif

// [core/bcc_sec_timer.v]
/*
  Seconds timer: loads a count of seconds and pulses once it has elapsed.
  Assumes a synchronous active-low reset and a free-running clock.
*/
`include "bcc_map.vh"

module bcc_sec_timer #(
  parameter CYC_PER_SEC = `BCC_CYC_PER_SEC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire load,
  input wire abort,
  input wire [15:0] load_sec,
  output reg expired
);

  reg [31:0] pre;
  reg [15:0] sec;
  reg active;

  // Prescaler to whole seconds, then seconds count-down
  always @(posedge ref_clk)
  begin
    if (!rst_n || abort)
    begin
      pre <= 32'h0000_0000;
      sec <= 16'h0000;
      active <= 1'b0;
      expired <= 1'b0;
    end
    else if (load)
    begin
      pre <= 32'h0000_0000;
      sec <= load_sec;
      active <= 1'b1;
      expired <= 1'b0;
    end
    else if (active)
    begin
      if (sec == 16'h0000)
      begin
        active <= 1'b0; // Zero seconds ends next edge
        expired <= 1'b1;
      end
      else if (pre == CYC_PER_SEC - 1)
      begin
        pre <= 32'h0000_0000;
        sec <= sec - 16'h0001;
        expired <= 1'b0;
      end
      else
      begin
        pre <= pre + 32'h0000_0001;
        expired <= 1'b0;
      end
    end
    else
    begin
      expired <= 1'b0;
    end
  end

endmodule // bcc_sec_timer

// [core/bcc_balance_ctrl.v]
/*
  Cell balance controller: setup and status registers, off, manual, timed
  and automatic balancing of twelve gate outputs.
  Assumes host register writes and the enable command come from logic on
  ref_clk, and the balance timeout (seconds) comes from the shared time
  register elsewhere in the device.
*/
// Summary of operation
// - Twelve gate outputs each drive one balancing transistor from host-set register bits.
// - Auto mode waits 0, 1, 2, 4, 8, 16, 32 or 64 s between cycles per the wait field.
// - Setup register at 6'h13 holds mode 1:0, wait 4:2, pointer 7:5 and 8, enable in 9.
// - The host sets all controls first; balancing starts when the enable bit becomes 1.
// - The enable bit is set by a setup register write or by the enable command.
// - Mode field 00 is off, 01 manual, 10 timed and 11 automatic.
// - Manual mode makes each output follow its host-written cell bit, untimed.
// - Timed mode turns every output off once the programmed duration has elapsed.
// - Auto mode removes a programmed charge from each cell over repeated cycles.
// - Status register at 6'h14 holds one bit per cell, cells one to twelve.
// - Pointer 0000 selects the status copy used by manual and timed modes.
// - Timed and auto modes take their timeout from the shared time register; manual does not.
// - Each nonzero pointer selects a separate automatic status register.
`include "bcc_map.vh"

module bcc_balance_ctrl #(
  parameter CELLS = 12,
  parameter AUTO_REGS = 15,
  parameter CYC_PER_SEC = `BCC_CYC_PER_SEC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire reg_wr,
  input wire [5:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire balance_enable_cmd,
  input wire [15:0] balance_time_sec,
  output reg [CELLS-1:0] balance_gate_outputs,
  output wire balance_busy
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [9:0] balance_setup;
  reg [CELLS-1:0] balance_cell_status;
  reg [CELLS-1:0] auto_status [1:AUTO_REGS];
  reg [2:0] state;
  reg [3:0] auto_idx;
  reg go_prev;
  reg [2:0] next_state;
  reg [3:0] next_auto_idx;
  reg next_load;
  reg [15:0] next_load_sec;
  reg next_go_clear;
  reg [CELLS-1:0] next_gates;
  reg tmr_load;
  reg [15:0] tmr_sec;
  wire tmr_expired;
  wire [1:0] balance_method_field;
  wire [2:0] balance_wait_field;
  wire [3:0] status_pointer_field;
  wire balance_go_bit;
  wire go_rise;
  integer i;

  // Wait field to seconds
  function [15:0] bcc_wait_sec;
    input [2:0] code;
    begin
      if (code == 3'h0)
        bcc_wait_sec = 16'h0000;
      else
        bcc_wait_sec = 16'h0001 << (code - 3'h1);
    end
  endfunction

  // Setup fields
  assign balance_method_field = balance_setup[`BCC_MODE_MSB:`BCC_MODE_LSB];
  assign balance_wait_field = balance_setup[`BCC_WAIT_MSB:`BCC_WAIT_LSB];
  assign status_pointer_field = {balance_setup[`BCC_PTR_HI_BIT],
    balance_setup[`BCC_PTR_LO_MSB:`BCC_PTR_LO_LSB]};
  assign balance_go_bit = balance_setup[`BCC_GO_BIT];
  assign go_rise = balance_go_bit && !go_prev;
  assign balance_busy = (state != ST_IDLE);

  // Register writes and enable bit; set wins over the hardware clear
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      balance_setup <= `BCC_SETUP_RST;
      balance_cell_status <= `BCC_STATUS_RST;
      for (i = 1; i <= AUTO_REGS; i = i + 1)
        auto_status[i] <= `BCC_STATUS_RST;
    end
    else
    begin
      if (reg_wr && reg_addr == `BCC_ADDR_SETUP)
        balance_setup <= reg_wdata[9:0];
      else if (balance_enable_cmd)
        balance_setup[`BCC_GO_BIT] <= 1'b1;
      else if (next_go_clear)
        balance_setup[`BCC_GO_BIT] <= 1'b0;
      if (reg_wr && reg_addr == `BCC_ADDR_STATUS)
      begin
        if (status_pointer_field == `BCC_PTR_MAIN)
          balance_cell_status <= reg_wdata[CELLS-1:0];
        else
          auto_status[status_pointer_field] <= reg_wdata[CELLS-1:0];
      end
    end
  end

  // Register reads, unmapped addresses read zero
  always @*
  begin
    reg_rdata = 16'h0000;
    if (reg_addr == `BCC_ADDR_SETUP)
      reg_rdata = {6'h00, balance_setup};
    else if (reg_addr == `BCC_ADDR_STATUS)
    begin
      if (status_pointer_field == `BCC_PTR_MAIN)
        reg_rdata[CELLS-1:0] = balance_cell_status;
      else
        reg_rdata[CELLS-1:0] = auto_status[status_pointer_field];
    end
  end

  // Balancing sequencer
  always @*
  begin
    next_state = state;
    next_auto_idx = auto_idx;
    next_load = 1'b0;
    next_load_sec = 16'h0000;
    next_go_clear = 1'b0;
    next_gates = {CELLS{1'b0}};
    case (state)
      ST_IDLE:
      begin
        if (go_rise && balance_method_field == `BCC_MODE_TIMED)
        begin
          next_state = ST_RUN;
          next_load = 1'b1;
          next_load_sec = balance_time_sec;
        end
        else if (go_rise && balance_method_field == `BCC_MODE_AUTO)
        begin
          next_state = ST_RUN;
          next_auto_idx = 4'h1;
          next_load = 1'b1;
          next_load_sec = balance_time_sec;
        end
      end
      ST_RUN:
      begin
        if (balance_method_field == `BCC_MODE_TIMED)
        begin
          next_gates = balance_cell_status;
          if (tmr_expired)
          begin
            next_gates = {CELLS{1'b0}};
            next_go_clear = 1'b1;
            next_state = ST_IDLE;
          end
        end
        else
        begin
          next_gates = auto_status[auto_idx];
          if (tmr_expired)
          begin
            next_gates = {CELLS{1'b0}};
            next_state = ST_WAIT;
            next_load = 1'b1;
            next_load_sec = bcc_wait_sec(balance_wait_field);
          end
        end
      end
      ST_WAIT:
      begin
        if (tmr_expired)
        begin
          if (auto_idx == AUTO_REGS || auto_status[auto_idx + 4'h1] == {CELLS{1'b0}})
          begin
            next_go_clear = 1'b1; // Charge delta fully removed
            next_state = ST_IDLE;
          end
          else
          begin
            next_auto_idx = auto_idx + 4'h1;
            next_state = ST_RUN;
            next_load = 1'b1;
            next_load_sec = balance_time_sec;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    // Host abandons, or selects off or manual mode
    if (!balance_go_bit || balance_method_field == `BCC_MODE_OFF
        || balance_method_field == `BCC_MODE_MANUAL)
    begin
      next_state = ST_IDLE;
      next_load = 1'b0;
      next_go_clear = 1'b0;
    end
    // Manual outputs follow the cell bits with no timing
    if (balance_method_field == `BCC_MODE_MANUAL)
      next_gates = balance_cell_status & {CELLS{balance_go_bit}};
    else if (balance_method_field == `BCC_MODE_OFF || !balance_go_bit)
      next_gates = {CELLS{1'b0}};
  end

  // State and registered gate outputs
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      auto_idx <= 4'h1;
      go_prev <= 1'b0;
      tmr_load <= 1'b0;
      tmr_sec <= 16'h0000;
      balance_gate_outputs <= {CELLS{1'b0}};
    end
    else
    begin
      state <= next_state;
      auto_idx <= next_auto_idx;
      go_prev <= balance_go_bit;
      tmr_load <= next_load;
      tmr_sec <= next_load_sec;
      balance_gate_outputs <= next_gates;
    end
  end

  // Shared seconds timer for duration and wait
  bcc_sec_timer #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .abort(state == ST_IDLE && !tmr_load),
    .load_sec(tmr_sec),
    .expired(tmr_expired)
  );

endmodule // bcc_balance_ctrl

// [sim/bcc_checker.sv]
/*
  Port checker for bcc_balance_ctrl.
  Assumes bind on ref_clk with reset rst_n.
*/
module bcc_checker #(
  parameter CELLS = 12
) (
  input logic ref_clk,
  input logic rst_n,
  input logic reg_wr,
  input logic [5:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic balance_enable_cmd,
  input logic [15:0] balance_time_sec,
  input logic [CELLS-1:0] balance_gate_outputs,
  input logic balance_busy
);
  // One clock, one reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Quiet outputs after reset
  property p_rst;
    $rose(rst_n) |-> balance_gate_outputs == 0 && !balance_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  // Unmapped reads give zero
  property p_unmap;
    reg_addr != 6'h13 && reg_addr != 6'h14 |-> reg_rdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Setup write shows next cycle
  property p_setup;
    reg_wr && reg_addr == 6'h13 |=> reg_addr != 6'h13 || reg_rdata[8:0] == $past(reg_wdata[8:0]);
  endproperty
  a_setup: assert property (p_setup) else $error("setup readback");
  // Status write shows next cycle
  property p_stat;
    reg_wr && reg_addr == 6'h14 |=> reg_addr != 6'h14 || reg_rdata[11:0] == $past(reg_wdata[11:0]);
  endproperty
  a_stat: assert property (p_stat) else $error("status readback");
  // Command sets enable bit
  property p_cmd;
    balance_enable_cmd && !(reg_wr && reg_addr == 6'h13) |=> reg_addr != 6'h13 || reg_rdata[9];
  endproperty
  a_cmd: assert property (p_cmd) else $error("command ignored");
  // Off mode forces gates low
  property p_off;
    reg_addr == 6'h13 && reg_rdata[1:0] == 2'h0 |=> balance_gate_outputs == 0;
  endproperty
  a_off: assert property (p_off) else $error("gates on in off");
  // Sequencer end turns gates off
  property p_end;
    $fell(balance_busy) |-> ##[0:2] balance_gate_outputs == 0;
  endproperty
  a_end: assert property (p_end) else $error("gates on after end");
  // Sequencer starts only after a request
  property p_start;
    $rose(balance_busy) |-> $past(reg_wr, 2) || $past(reg_wr, 3) || $past(balance_enable_cmd, 2)
      || $past(balance_enable_cmd, 3);
  endproperty
  a_start: assert property (p_start) else $error("start without request");
endmodule // bcc_checker

bind bcc_balance_ctrl bcc_checker #(.CELLS(CELLS)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .balance_enable_cmd(balance_enable_cmd), .balance_time_sec(balance_time_sec),
  .balance_gate_outputs(balance_gate_outputs), .balance_busy(balance_busy));

// [sim/bcc_fet_bank.sv]
/*
  Model of the twelve external balancing transistors.
  Assumes active-high gate drive on ref_clk.
*/
module bcc_fet_bank (
  input logic ref_clk,
  input logic rst_n,
  input logic [11:0] gate,
  output logic [11:0] conducting
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each transistor conducts one clock after its gate
  always @(posedge ref_clk)
  begin
    conducting <= rst_n ? gate : 12'h000;
  end
endmodule // bcc_fet_bank

// [sim/test_cell_balance_control.sv]
/*
  Self-checking bench for the balance controller.
  Assumes CYC_PER_SEC of 10, so one second is ten clocks.
*/
module test_cell_balance_control;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [9:0] s; logic [11:0] st; logic [11:0] ex;} bcc_row_t;
  logic ref_clk, rst_n, reg_wr, cmd, busy;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, t_sec, v;
  logic [11:0] gates, cond;
  int errors, cmp_count, n;
  bcc_row_t rows[4] = '{'{10'h201, 12'hA5A, 12'hA5A}, '{10'h001, 12'hFFF, 12'h000},
    '{10'h200, 12'hFFF, 12'h000}, '{10'h201, 12'h801, 12'h801}};
  bcc_balance_ctrl #(.CYC_PER_SEC(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .balance_enable_cmd(cmd), .balance_time_sec(t_sec), .balance_gate_outputs(gates),
    .balance_busy(busy));
  bcc_fet_bank fets (.ref_clk(ref_clk), .rst_n(rst_n), .gate(gates), .conducting(cond));
  // Clock, 100 ns period
  initial
  begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Bus and compare helpers
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(1);
  endtask
  task automatic rd(logic [5:0] a);
    reg_addr = a;
    tick(1);
    v = reg_rdata;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_g(logic [11:0] g);
    n = 0;
    while (gates !== g && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask
  task results;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_n = 0;
    reg_wr = 0;
    cmd = 0;
    reg_addr = 0;
    reg_wdata = 0;
    t_sec = 16'h0002;
    tick(6);
    chk(gates, 0);
    rst_n = 1;
    foreach (rows[i])
    begin
      wr(6'h13, rows[i].s & 10'h1FF);
      wr(6'h14, rows[i].st);
      wr(6'h13, rows[i].s);
      tick(2);
      chk(gates, rows[i].ex);
      chk(cond, rows[i].ex);
    end
    wr(6'h15, 16'hFFFF);
    rd(6'h15);
    chk(v, 0);
    rd(6'h14);
    chk(v, 16'h0801);
    // Enable command in manual mode, timeout unused
    wr(6'h13, 16'h0001);
    rd(6'h13);
    cmd = 1;
    tick(1);
    cmd = 0;
    rd(6'h13);
    chk(v, 16'h0201);
    tick(30);
    chk(gates, 12'h801);
    // Timed mode, two seconds
    wr(6'h13, 16'h0002);
    wr(6'h13, 16'h0202);
    wait_g(12'h801);
    chk(gates, 12'h801);
    wait_g(0);
    chk(16'(n >= 18 && n <= 22), 1);
    rd(6'h13);
    chk(v, 16'h0002);
    // Auto mode over two cell sets, four second wait
    t_sec = 16'h0001;
    wr(6'h13, 16'h0027);
    wr(6'h14, 16'h0003);
    wr(6'h13, 16'h0047);
    wr(6'h14, 16'h0C00);
    wr(6'h13, 16'h0067);
    wr(6'h14, 16'h0000);
    wr(6'h13, 16'h0027);
    rd(6'h14);
    chk(v, 16'h0003);
    wr(6'h13, 16'h0007);
    rd(6'h14);
    chk(v, 16'h0801);
    wr(6'h13, 16'h020F);
    wait_g(12'h003);
    chk(gates, 12'h003);
    wait_g(0);
    chk(16'(n >= 8 && n <= 12), 1);
    wait_g(12'hC00);
    chk(16'(n >= 40 && n <= 44), 1);
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      tick(1);
      n++;
    end
    chk(busy, 0);
    rd(6'h13);
    chk(v, 16'h000F);
    // Reset in mid-run clears registers and gates
    wr(6'h13, 16'h0201);
    tick(2);
    chk(gates, 12'h801);
    rst_n = 0;
    tick(1);
    rst_n = 1;
    tick(1);
    chk(gates, 0);
    rd(6'h13);
    chk(v, 0);
    rd(6'h14);
    chk(v, 0);
    results;
  end
  // Watchdog
  initial
  begin
    #1000000;
    errors++;
    results;
  end
endmodule // test_cell_balance_control
